//--- msc_pkg.sv
// Shared constants for the motion supervisor
package msc_pkg;
  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CMD = 8'h04;
  localparam logic [7:0] A_DO_BASE = 8'h10;
  localparam logic [7:0] A_STAT = 8'h20;
  localparam logic [7:0] A_ECHO = 8'h24;
  localparam logic [7:0] A_DI_BASE = 8'h30;
  localparam logic [7:0] A_IRQ_ST = 8'h40;
  localparam logic [7:0] A_IRQ_MSK = 8'h44;
  localparam logic [7:0] A_SERCFG = 8'h48;
  // Command word opcode field
  localparam int OP_HI = 15;
  localparam int OP_LO = 12;
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_GET = 4'h1;
  localparam logic [3:0] OP_SETLIM = 4'h2;
  localparam logic [3:0] OP_MOVE = 4'h3;
  localparam logic [3:0] OP_STOP = 4'h4;
  localparam logic [3:0] OP_HOME = 4'h5;
  localparam logic [3:0] OP_SETSER = 4'h6;
  localparam logic [3:0] OP_CLEAR = 4'h7;
  localparam logic [3:0] OP_LOCK = 4'h8;
  localparam logic [3:0] OP_RELEASE = 4'h9;
  localparam logic [3:0] OP_RDLOG = 4'hA;
  // Status word bit positions
  localparam int ST_FATAL = 0;
  localparam int ST_SOFT = 1;
  localparam int ST_LKFLT = 2;
  localparam int ST_LOCK = 3;
  localparam int ST_HOMED = 4;
  localparam int ST_HOMING = 5;
  localparam int ST_DRIVE = 6;
  localparam int ST_CFGDEF = 7;
  localparam int ST_CTLPRIV = 8;
  localparam int ST_REJ = 9;
  // Interrupt bits
  localparam int IRQ_W = 4;
  localparam int IRQ_FATAL = 0;
  localparam int IRQ_SOFT = 1;
  localparam int IRQ_REJ = 2;
  localparam int IRQ_HOME = 3;
  // Serial framing: [3:0] baud code, [4] parity on, [5] odd, [6] eight bits, [7] two stops
  localparam int SER_DATA_BITS = 7;
  localparam int SER_BAUD = 9600;
  localparam logic [3:0] SC_BAUD_9600 = 4'h7;
  localparam logic [15:0] SC_DEFAULT = {8'h00, 4'h1, SC_BAUD_9600};
  // Reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [31:0] RST_LIM_HI = 32'h7FFFFFFF;
  localparam logic [31:0] RST_LIM_LO = 32'h80000000;
endpackage

//--- msc_axis_if.sv
// Axis signals shared between the supervisor and its limit and home units
`timescale 1ns/1ns
`default_nettype none
interface msc_axis_if;
  logic [31:0] position;
  logic pos_lim_ok;
  logic neg_lim_ok;
  logic [31:0] soft_hi;
  logic [31:0] soft_lo;
  logic clr_fault;
  logic fatal;
  logic soft_stop;
  logic home_open;
  logic fb_zero;
  logic hom_start;
  logic hom_abort;
  logic homed;
  logic homing;
  logic home_done;
  modport lim (input position, pos_lim_ok, neg_lim_ok, soft_hi, soft_lo, clr_fault, output fatal, soft_stop);
  modport hom (input home_open, fb_zero, hom_start, hom_abort, output homed, homing, home_done);
endinterface
`default_nettype wire

//--- msc_limit.sv
// Hardware and programmable end-of-travel supervision
`timescale 1ns/1ns
`default_nettype none
module msc_limit
  import msc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Axis
  msc_axis_if.lim ax
);
  logic fatal_q;
  logic soft_q;
  logic trip;
  logic over;

  assign trip = !ax.pos_lim_ok || !ax.neg_lim_ok;
  assign over = ($signed(ax.position) > $signed(ax.soft_hi)) || ($signed(ax.position) < $signed(ax.soft_lo));
  assign ax.fatal = fatal_q;
  assign ax.soft_stop = soft_q;

  // Fatal trip latches until cleared, a trip in the clear cycle wins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fatal_q <= 1'b0;
    end else begin
      fatal_q <= trip || (fatal_q && !ax.clr_fault);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      soft_q <= 1'b0;
    end else begin
      soft_q <= over || (soft_q && !ax.clr_fault);
    end
  end

  a_hw_trip: assert property (@(posedge mclk) disable iff (!rst_n)
    trip |=> fatal_q) else $error("travel limit did not trip fatal");
  a_soft_trip: assert property (@(posedge mclk) disable iff (!rst_n)
    over && !trip |=> soft_q ##0 !$rose(fatal_q)) else $error("soft limit not flagged as non-fatal");
endmodule
`default_nettype wire

//--- msc_home.sv
// Home detection: switch open together with feedback zero
`timescale 1ns/1ns
`default_nettype none
module msc_home
  import msc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Axis
  msc_axis_if.hom ax
);
  typedef enum logic [0:0] {H_IDLE, H_SEEK} msc_hstate_t;
  msc_hstate_t st_q;
  logic homed_q;
  logic done_q;
  logic hit;

  assign hit = ax.home_open && ax.fb_zero;
  assign ax.homed = homed_q;
  assign ax.homing = (st_q == H_SEEK);
  assign ax.home_done = done_q;

  // First zero seen while the switch is open ends the search
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= H_IDLE;
    end else begin
      case (st_q)
        H_IDLE: begin
          if (ax.hom_start) st_q <= H_SEEK;
        end
        H_SEEK: begin
          if (ax.hom_abort || hit) st_q <= H_IDLE;
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      homed_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= (st_q == H_SEEK) && !ax.hom_abort && hit;
      if (ax.hom_start) homed_q <= 1'b0;
      else if ((st_q == H_SEEK) && !ax.hom_abort && hit) homed_q <= 1'b1;
    end
  end

  a_home_cause: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(homed_q) |-> $past(ax.home_open) && $past(ax.fb_zero)) else $error("homed without switch and zero");
  a_first_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_q == H_SEEK) && hit && !ax.hom_abort |=> homed_q && done_q && (st_q == H_IDLE)) else $error("first zero missed");
endmodule
`default_nettype wire

//--- msc_top.sv
// Motion supervisor: register exchange, privilege, lockout, serial framing, drive control
// Behaviour
// - Port-config switch sampled once after reset: closed gives default framing, open the saved one.
// - Default framing: one start, seven data, one stop, even parity, 9600 baud.
// - Serial framing changes accepted later only while the port-config switch is open.
// - Either travel-limit input low raises a fatal error.
// - Reaching a hardware travel limit drops drive enable and stops the motor.
// - Crossing a programmed soft limit stops the drive with a non-fatal error.
// - Homed only when home switch open and feedback at zero together.
// - Homing takes the first feedback zero after the home switch opens.
// - Exchanges use six outgoing and six incoming registers in fixed order.
// - First incoming register is status, second an exact echo of the command.
// - Remaining four registers each way carry data words one to four.
// - Under lockout, serial set or motion commands are rejected and a fault set.
// - Only a controller release command clears lockout; the serial tool cannot.
// - Under lockout the controller holds write privilege unconditionally.
// - Without lockout and both talking, the sampled control-source switch picks the writer.
// - Reads always allowed, but reading the error log needs write privilege.
`timescale 1ns/1ns
`default_nettype none
module msc_top
  import msc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Wishbone slave, used by the programmable controller
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  // Switches and stored framing
  input wire logic port_config_switch,
  input wire logic control_source_switch,
  input wire logic [15:0] saved_serial_cfg,
  output logic [15:0] serial_cfg,
  // Serial setup tool command port
  input wire logic ser_link_ok,
  input wire logic plc_link_ok,
  input wire logic ser_cmd_valid,
  input wire logic [15:0] ser_cmd_word,
  input wire logic [63:0] ser_cmd_data,
  output logic ser_cmd_ready,
  output logic ser_cmd_done,
  output logic ser_cmd_reject,
  output logic [15:0] ser_status,
  output logic [63:0] ser_resp,
  // Axis
  input wire logic positive_travel_limit,
  input wire logic negative_travel_limit,
  input wire logic home_switch_open,
  input wire logic feedback_zero,
  input wire logic [31:0] position,
  output logic drive_enable,
  output logic motor_stop,
  output logic motion_dir
);
  function automatic logic [15:0] wb_merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    wb_merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic is_set_motion(input logic [3:0] op);
    is_set_motion = (op == OP_SETLIM) || (op == OP_MOVE) || (op == OP_STOP) || (op == OP_HOME) ||
                    (op == OP_SETSER) || (op == OP_CLEAR);
  endfunction

  msc_axis_if ax();
  msc_limit u_limit (.mclk(mclk), .rst_n(rst_n), .ax(ax));
  msc_home u_home (.mclk(mclk), .rst_n(rst_n), .ax(ax));

  logic ack_q;
  logic [31:0] rd_q;
  logic [31:0] rd_d;
  logic [15:0] ctrl_q;
  logic [15:0] cmd_q;
  logic [15:0] echo_q;
  logic [15:0] do_q [0:3];
  logic [15:0] di_q [0:3];
  logic [15:0] stat_q;
  logic [15:0] stat_d;
  logic [15:0] ser_cfg_q;
  logic [15:0] log_q;
  logic [IRQ_W-1:0] irq_st_q;
  logic [IRQ_W-1:0] irq_msk_q;
  logic [IRQ_W-1:0] ev;
  logic [31:0] lim_hi_q;
  logic [31:0] lim_lo_q;
  logic init_q;
  logic src_ser_q;
  logic lockout_q;
  logic lk_fault_q;
  logic rej_q;
  logic run_q;
  logic dir_q;
  logic drive_q;
  logic hom_start_q;
  logic ser_done_q;
  logic ser_rej_q;
  logic [7:0] adr;
  logic wb_req;
  logic wb_wr;
  logic ctl_stb;
  logic ser_take;
  logic cmd_go;
  logic [15:0] ctl_word;
  logic [15:0] cur_word;
  logic [3:0] cur_op;
  logic [63:0] cur_data;
  logic ctl_priv;
  logic ser_priv;
  logic cur_priv;
  logic acc;
  logic rej;
  logic lk_fault;

  assign adr = {wb_adr_i[7:2], 2'b00};
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wb_wr = wb_req && wb_we_i;
  assign ctl_word = wb_merge(cmd_q, wb_dat_i, wb_sel_i);
  assign ctl_stb = wb_wr && (adr == A_CMD);
  assign ser_cmd_ready = init_q && !ctl_stb;
  assign ser_take = ser_cmd_valid && ser_cmd_ready;
  assign cmd_go = ctl_stb || ser_take;
  assign cur_word = ctl_stb ? ctl_word : ser_cmd_word;
  assign cur_op = cur_word[OP_HI:OP_LO];
  assign cur_data = ctl_stb ? {do_q[3], do_q[2], do_q[1], do_q[0]} : ser_cmd_data;

  // Write privilege
  assign ctl_priv = lockout_q || !ser_link_ok || !src_ser_q;
  assign ser_priv = !lockout_q && (!plc_link_ok || src_ser_q);
  assign cur_priv = ctl_stb ? ctl_priv : ser_priv;

  // Command acceptance
  always_comb begin
    acc = 1'b0;
    rej = 1'b0;
    lk_fault = 1'b0;
    if (cmd_go) begin
      if (!ctl_stb && lockout_q && is_set_motion(cur_op)) begin
        rej = 1'b1;
        lk_fault = 1'b1;
      end else if (!ctl_stb && ((cur_op == OP_LOCK) || (cur_op == OP_RELEASE))) begin
        rej = 1'b1;
      end else if ((cur_op == OP_SETSER) && port_config_switch) begin
        rej = 1'b1;
      end else if ((is_set_motion(cur_op) || (cur_op == OP_RDLOG)) && !cur_priv) begin
        rej = 1'b1;
      end else if (cur_op > OP_RDLOG) begin
        rej = 1'b1;
      end else begin
        acc = 1'b1;
      end
    end
  end

  // Straps caught once after reset release
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      init_q <= 1'b0;
      src_ser_q <= 1'b0;
    end else if (!init_q) begin
      init_q <= 1'b1;
      src_ser_q <= control_source_switch;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ser_cfg_q <= SC_DEFAULT;
    end else if (!init_q) begin
      ser_cfg_q <= port_config_switch ? SC_DEFAULT : saved_serial_cfg;
    end else if (acc && (cur_op == OP_SETSER)) begin
      ser_cfg_q <= cur_data[15:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lockout_q <= 1'b0;
    end else if (acc && (cur_op == OP_LOCK)) begin
      lockout_q <= 1'b1;
    end else if (acc && (cur_op == OP_RELEASE)) begin
      lockout_q <= 1'b0;
    end
  end

  // Sticky lockout fault bit, a new fault beats a clear; reject flag holds the last command's outcome
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lk_fault_q <= 1'b0;
      rej_q <= 1'b0;
    end else begin
      lk_fault_q <= lk_fault || (lk_fault_q && !(acc && (cur_op == OP_CLEAR)));
      if (cmd_go) rej_q <= rej;
    end
  end

  // Host register writes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= RST_WORD;
      cmd_q <= RST_WORD;
      echo_q <= RST_WORD;
      for (int i = 0; i < 4; i++) do_q[i] <= RST_WORD;
    end else begin
      if (wb_wr && (adr == A_CTRL)) ctrl_q <= wb_merge(ctrl_q, wb_dat_i, wb_sel_i);
      if (ctl_stb) cmd_q <= ctl_word;
      if (ctl_stb) echo_q <= ctl_word;
      if (wb_wr && (adr[7:4] == A_DO_BASE[7:4])) do_q[adr[3:2]] <= wb_merge(do_q[adr[3:2]], wb_dat_i, wb_sel_i);
    end
  end

  // Returned data words and error log
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) di_q[i] <= RST_WORD;
      log_q <= RST_WORD;
    end else begin
      log_q <= {12'h000, ev} | ((acc && (cur_op == OP_RDLOG)) ? RST_WORD : log_q);
      if (acc && (cur_op == OP_GET)) begin
        di_q[0] <= position[15:0];
        di_q[1] <= position[31:16];
        di_q[2] <= ser_cfg_q;
        di_q[3] <= stat_q;
      end else if (acc && (cur_op == OP_RDLOG)) begin
        di_q[3] <= log_q;
      end
    end
  end

  // Soft limits, motion and homing commands
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lim_hi_q <= RST_LIM_HI;
      lim_lo_q <= RST_LIM_LO;
    end else if (acc && (cur_op == OP_SETLIM)) begin
      lim_hi_q <= cur_data[31:0];
      lim_lo_q <= cur_data[63:32];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= 1'b0;
      dir_q <= 1'b0;
      hom_start_q <= 1'b0;
    end else begin
      hom_start_q <= acc && (cur_op == OP_HOME);
      if (ax.fatal || ax.soft_stop || (acc && (cur_op == OP_STOP)) || ax.home_done) begin
        run_q <= 1'b0;
      end else if (acc && ((cur_op == OP_MOVE) || (cur_op == OP_HOME))) begin
        run_q <= 1'b1;
        dir_q <= cur_data[0];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      drive_q <= 1'b0;
    end else begin
      drive_q <= run_q && !ax.fatal && !ax.soft_stop && positive_travel_limit && negative_travel_limit;
    end
  end

  assign ax.position = position;
  assign ax.pos_lim_ok = positive_travel_limit;
  assign ax.neg_lim_ok = negative_travel_limit;
  assign ax.soft_hi = lim_hi_q;
  assign ax.soft_lo = lim_lo_q;
  assign ax.clr_fault = acc && (cur_op == OP_CLEAR);
  assign ax.home_open = home_switch_open;
  assign ax.fb_zero = feedback_zero;
  assign ax.hom_start = hom_start_q;
  assign ax.hom_abort = ax.fatal || ax.soft_stop || (acc && (cur_op == OP_STOP));

  // Status word
  always_comb begin
    stat_d = RST_WORD;
    stat_d[ST_FATAL] = ax.fatal;
    stat_d[ST_SOFT] = ax.soft_stop;
    stat_d[ST_LKFLT] = lk_fault_q;
    stat_d[ST_LOCK] = lockout_q;
    stat_d[ST_HOMED] = ax.homed;
    stat_d[ST_HOMING] = ax.homing;
    stat_d[ST_DRIVE] = drive_q;
    stat_d[ST_CFGDEF] = (ser_cfg_q == SC_DEFAULT);
    stat_d[ST_CTLPRIV] = ctl_priv;
    stat_d[ST_REJ] = rej_q;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= RST_WORD;
    end else begin
      stat_q <= stat_d;
    end
  end

  // Interrupt status, write one to clear, events win
  assign ev = {ax.home_done, rej, ax.soft_stop && !stat_q[ST_SOFT], ax.fatal && !stat_q[ST_FATAL]};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_st_q <= '0;
      irq_msk_q <= '0;
    end else begin
      irq_st_q <= ev | (irq_st_q & ~((wb_wr && (adr == A_IRQ_ST) && wb_sel_i[0]) ? wb_dat_i[IRQ_W-1:0] : '0));
      if (wb_wr && (adr == A_IRQ_MSK) && wb_sel_i[0]) irq_msk_q <= wb_dat_i[IRQ_W-1:0];
    end
  end

  // Read mux, unmapped words read zero
  always_comb begin
    rd_d = 32'h00000000;
    case (adr)
      A_CTRL: rd_d[15:0] = ctrl_q;
      A_CMD: rd_d[15:0] = cmd_q;
      A_STAT: rd_d[15:0] = stat_q;
      A_ECHO: rd_d[15:0] = echo_q;
      A_IRQ_ST: rd_d[IRQ_W-1:0] = irq_st_q;
      A_IRQ_MSK: rd_d[IRQ_W-1:0] = irq_msk_q;
      A_SERCFG: rd_d[15:0] = ser_cfg_q;
      default: begin
        if (adr[7:4] == A_DO_BASE[7:4]) rd_d[15:0] = do_q[adr[3:2]];
        else if (adr[7:4] == A_DI_BASE[7:4]) rd_d[15:0] = di_q[adr[3:2]];
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      rd_q <= 32'h00000000;
      ser_done_q <= 1'b0;
      ser_rej_q <= 1'b0;
    end else begin
      ack_q <= wb_req;
      if (wb_req) rd_q <= rd_d;
      ser_done_q <= ser_take && acc;
      ser_rej_q <= ser_take && rej;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rd_q;
  assign irq = |(irq_st_q & irq_msk_q);
  assign serial_cfg = ser_cfg_q;
  assign ser_cmd_done = ser_done_q;
  assign ser_cmd_reject = ser_rej_q;
  assign ser_status = stat_q;
  assign ser_resp = {di_q[3], di_q[2], di_q[1], di_q[0]};
  assign drive_enable = drive_q;
  assign motor_stop = !drive_q;
  assign motion_dir = dir_q;

  a_cfg_default: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(init_q) && $past(port_config_switch) |-> ser_cfg_q == SC_DEFAULT) else $error("default framing not taken");
  a_ser_cfg_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    init_q && cmd_go && (cur_op == OP_SETSER) && port_config_switch |=> $stable(ser_cfg_q)) else $error("framing changed while switch closed");
  a_drive_off: assert property (@(posedge mclk) disable iff (!rst_n)
    !positive_travel_limit || !negative_travel_limit |=> !drive_enable ##1 !drive_enable) else $error("drive on at travel limit");
  a_soft_stop: assert property (@(posedge mclk) disable iff (!rst_n)
    ax.soft_stop |=> !run_q && !drive_enable) else $error("drive on past soft limit");
  a_echo_copy: assert property (@(posedge mclk) disable iff (!rst_n)
    ctl_stb |=> echo_q == $past(ctl_word)) else $error("echo differs from command");
  a_lock_reject: assert property (@(posedge mclk) disable iff (!rst_n)
    ser_take && lockout_q && is_set_motion(cur_op) |=> ser_cmd_reject && lk_fault_q ##1 stat_q[ST_LKFLT]) else $error("locked-out serial command not rejected");
  a_no_ser_release: assert property (@(posedge mclk) disable iff (!rst_n)
    lockout_q && !(ctl_stb && (cur_op == OP_RELEASE)) |=> lockout_q) else $error("lockout left without controller release");
  a_lock_priv: assert property (@(posedge mclk) disable iff (!rst_n)
    lockout_q |-> ctl_priv && !ser_priv) else $error("controller lacks privilege under lockout");
  a_src_switch: assert property (@(posedge mclk) disable iff (!rst_n)
    init_q && !lockout_q && plc_link_ok && ser_link_ok |-> (ser_priv == src_ser_q) && (ctl_priv != src_ser_q)) else $error("source switch ignored");
  a_log_priv: assert property (@(posedge mclk) disable iff (!rst_n)
    cmd_go && (cur_op == OP_RDLOG) && !cur_priv |=> $stable(di_q[3]) && rej_q) else $error("log read without privilege");
  a_stat_fatal: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(ax.fatal) |=> stat_q[ST_FATAL] && !stat_q[ST_DRIVE]) else $error("fatal missing from status");
endmodule
`default_nettype wire

//--- msc_ser_host.sv
// Serial setup tool model on the command port
`timescale 1ns/1ns
`default_nettype none
module msc_ser_host (
  // Clock and answer
  input wire logic mclk,
  input wire logic ready,
  input wire logic done,
  input wire logic reject,
  // Request
  output logic valid,
  output logic [15:0] word,
  output logic [63:0] data
);
  initial begin
    valid = 1'b0;
    word = 16'h0000;
    data = 64'h0;
  end
  // Holds the request until ready is seen at a rising edge, scrambles it on release; ans is {done, reject}
  task automatic send(input logic [15:0] w, input logic [63:0] d, output logic [1:0] ans);
    @(posedge mclk);
    valid <= 1'b1;
    word <= w;
    data <= d;
    do @(posedge mclk); while (ready !== 1'b1);
    valid <= 1'b0;
    word <= ~w;
    data <= ~d;
    @(posedge mclk);
    ans = {done, reject};
  endtask
endmodule
`default_nettype wire

//--- tb_motion_supervisor_control.sv
// Self-checking bench for the motion supervisor
`timescale 1ns/1ns
`default_nettype none
module tb_motion_supervisor_control;
  import msc_pkg::*;
  typedef struct packed {logic [7:0] adr; logic [15:0] wd; logic [7:0] ra; logic [15:0] ex;} msc_row_t;
  msc_row_t rows [4] = '{'{A_CMD, 16'h1234, A_ECHO, 16'h1234}, '{A_CMD, 16'hF00F, A_ECHO, 16'hF00F},
    '{8'h50, 16'hFFFF, 8'h50, 16'h0000}, '{A_SERCFG, 16'h00FF, A_SERCFG, SC_DEFAULT}};
  logic mclk = 1'b0, rst_n = 1'b0, cyc = 1'b0, we = 1'b0, pcfg = 1'b1, slink = 1'b1;
  logic plim = 1'b1, hopen = 1'b0, fz = 1'b0, src = 1'b1, plc = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [15:0] saved = 16'h00A3;
  logic [31:0] wd = 32'h0, pos = 32'h0, rd, dat_o;
  logic ack, irq, srdy, sdone, srej, sv, drv, mstop, mdir;
  logic [1:0] ans;
  logic [15:0] cfg, sst, sw;
  logic [63:0] sd, resp;
  int error_cnt = 0, check_count = 0, cycles = 0;
  always #20 mclk = ~mclk;
  msc_ser_host i_ser (.mclk(mclk), .ready(srdy), .done(sdone), .reject(srej), .valid(sv), .word(sw), .data(sd));
  msc_top i_dut (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(dat_o), .wb_ack_o(ack), .irq(irq), .port_config_switch(pcfg),
    .control_source_switch(src), .saved_serial_cfg(saved), .serial_cfg(cfg), .ser_link_ok(slink),
    .plc_link_ok(plc), .ser_cmd_valid(sv), .ser_cmd_word(sw), .ser_cmd_data(sd), .ser_cmd_ready(srdy),
    .ser_cmd_done(sdone), .ser_cmd_reject(srej), .ser_status(sst), .ser_resp(resp), .positive_travel_limit(plim),
    .negative_travel_limit(1'b1), .home_switch_open(hopen), .feedback_zero(fz), .position(pos),
    .drive_enable(drv), .motor_stop(mstop), .motion_dir(mdir));
  task automatic print_verdict();
    $display("errors %0d, checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge mclk) if (++cycles == 4000) begin
    error_cnt++;
    print_verdict();
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  // Classic single cycle, waits for ack, then releases
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wd <= {16'h0000, d};
    do @(posedge mclk); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
  endtask
  task automatic cmd(input logic [15:0] w);
    wb(1'b1, A_CMD, w);
    repeat (3) @(posedge mclk);
  endtask
  task automatic reset();
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({drv, mstop}, 2'b01);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask
  initial begin
    reset();
    chk({cfg, sst[ST_CFGDEF]}, {SC_DEFAULT, 1'b1});
    foreach (rows[i]) begin
      wb(1'b1, rows[i].adr, rows[i].wd);
      wb(1'b0, rows[i].ra, 16'h0000);
      chk(rd, {16'h0000, rows[i].ex});
    end
    i_ser.send(16'h6000, 64'h15, ans);
    chk(ans, 2'b01);
    i_ser.send(16'h3000, 64'h1, ans);
    chk({ans, mdir}, 3'b101);
    i_ser.send(16'h4000, 64'h0, ans);
    chk(ans, 2'b10);
    cmd(16'h8000);
    i_ser.send(16'h3000, 64'h0, ans);
    chk(ans, 2'b01);
    repeat (2) @(posedge mclk);
    chk({sst[ST_LKFLT], sst[ST_LOCK], sst[ST_CTLPRIV], sst[ST_REJ]}, 4'b1111);
    i_ser.send(16'h9000, 64'h0, ans);
    chk(ans, 2'b01);
    cmd(16'h9000);
    chk(sst[ST_LOCK], 1'b0);
    slink <= 1'b0;
    cmd(16'h5000);
    fz <= 1'b1;
    @(posedge mclk);
    fz <= 1'b0;
    hopen <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({sst[ST_HOMED], sst[ST_HOMING]}, 2'b01);
    fz <= 1'b1;
    @(posedge mclk);
    fz <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({sst[ST_HOMED], sst[ST_HOMING]}, 2'b10);
    foreach (rows[i]) wb(1'b1, A_DO_BASE + 8'(4 * i), i[0] ? {16{i[1]}} : (i[1] ? 16'hFF9C : 16'h0064));
    cmd(16'h2000);
    cmd(16'h3000);
    chk({drv, sst[ST_DRIVE]}, 2'b11);
    pos <= 32'd200;
    repeat (3) @(posedge mclk);
    chk({sst[ST_SOFT], sst[ST_FATAL], drv}, 3'b100);
    pos <= 32'h0;
    cmd(16'h7000);
    wb(1'b1, A_IRQ_MSK, 16'h0001);
    cmd(16'h3000);
    plim <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({drv, mstop, sst[ST_FATAL], irq}, 4'b0111);
    plim <= 1'b1;
    cmd(16'h3000);
    chk(drv, 1'b0);
    cmd(16'h7000);
    wb(1'b1, A_IRQ_ST, 16'h000F);
    repeat (2) @(posedge mclk);
    chk({sst[ST_FATAL], irq}, 2'b00);
    pcfg <= 1'b0;
    slink <= 1'b1;
    src <= 1'b0;
    reset();
    chk(cfg, saved);
    i_ser.send(16'hA000, 64'h0, ans);
    chk({ans, sst[ST_CTLPRIV]}, 3'b011);
    plc <= 1'b0;
    i_ser.send(16'h6000, 64'h15, ans);
    chk(ans, 2'b10);
    i_ser.send(16'hA000, 64'h0, ans);
    repeat (2) @(posedge mclk);
    chk({ans, cfg, sst[ST_CFGDEF]}, {2'b10, 16'h0015, 1'b0});
    chk(resp[63:48], 16'h0004);
    print_verdict();
  end
endmodule
`default_nettype wire
